// ===== tb/hsps_host_model.sv
// Host model: serial peer, four-wire controller and two-wire controller.
// Assumes the bench sets rx_bit_ns to the device's nominal bit time.
`timescale 1ns/100ps
module hsps_host_model (
	output logic uart_rxd,
	input wire logic uart_txd,
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe,
	output logic twi_scl_i,
	output logic twi_sda_i,
	input wire logic twi_scl_o,
	input wire logic twi_scl_oe,
	input wire logic twi_sda_o,
	input wire logic twi_sda_oe,
	output logic [7:0] got_byte,
	output logic got_flag
);
	realtime rx_bit_ns = 8680.6;
	logic scl_h = 1'b1;
	logic sda_h = 1'b1;
	logic [7:0] d;
	logic miso_w;
	// Pull-ups on every shared pin
	assign twi_scl_i = scl_h & (twi_scl_oe ? twi_scl_o : 1'b1);
	assign twi_sda_i = sda_h & (twi_sda_oe ? twi_sda_o : 1'b1);
	assign miso_w = spi_miso_oe ? spi_miso_o : 1'b1;
	initial begin
		uart_rxd = 1'b1;
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
		got_flag = 1'b0;
		got_byte = 8'h00;
	end
	// No handshake lines, so each character is taken as it comes
	always @(negedge uart_txd) begin
		#(rx_bit_ns / 2);
		if (uart_txd === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				#(rx_bit_ns);
				d[i] = uart_txd;
			end
			#(rx_bit_ns);
			got_byte = uart_txd === 1'b1 ? d : 8'hxx;
			got_flag = 1'b1;
			#1 got_flag = 1'b0;
		end
	end
	task automatic uart_send(input logic [7:0] b, input realtime bit_ns);
		uart_rxd = 1'b0;
		#(bit_ns);
		for (int i = 0; i < 8; i++) begin
			uart_rxd = b[i];
			#(bit_ns);
		end
		uart_rxd = 1'b1;
		#(bit_ns);
	endtask
	task automatic spi_xfer(input logic [7:0] mo, output logic [7:0] mi);
		#7;
		spi_cs_n = 1'b0;
		#4;
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = mo[i];
			#16;
			spi_sck = 1'b1;
			mi[i] = miso_w;
			#16;
			spi_sck = 1'b0;
		end
		#30;
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
	endtask
	// 1.3 us low, 1.2 us high: 400 kHz at most
	task automatic twi_bit(input logic b, output logic s);
		#300;
		sda_h = b;
		#1000;
		scl_h = 1'b1;
		wait (twi_scl_i === 1'b1);
		#600;
		s = twi_sda_i;
		#600;
		scl_h = 1'b0;
	endtask
	task automatic twi_xfer(input logic [6:0] a, input logic rd, input logic [7:0] b,
		output logic [8:0] ra, output logic [8:0] rb);
		logic [8:0] ta;
		logic [8:0] tb;
		ta = {a, rd, 1'b1};
		tb = rd ? 9'h1ff : {b, 1'b1};
		sda_h = 1'b0;
		#600;
		scl_h = 1'b0;
		for (int i = 8; i >= 0; i--) begin
			twi_bit(ta[i], ra[i]);
		end
		for (int i = 8; i >= 0; i--) begin
			twi_bit(tb[i], rb[i]);
		end
		#300;
		sda_h = 1'b0;
		#1000;
		scl_h = 1'b1;
		#600;
		sda_h = 1'b1;
		#1300;
	endtask
endmodule

// ===== tb/hsps_properties.sv
// Concurrent checks on the pins of the host port front end.
// Assumes it is bound to hsps_top with the stretch limit handed on.
`timescale 1ns/100ps
module hsps_checker #(
	parameter int STRETCH_LIMIT = 200
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic spi_cs_n,
	input wire logic uart_txd,
	input wire logic rx_valid,
	input wire hsps_pkg::hsps_rx_s rx_byte,
	input wire hsps_pkg::hsps_mode_e port_mode,
	input wire logic spi_miso_oe,
	input wire logic twi_scl_oe,
	input wire logic twi_sda_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// ---------------------------------------------------------------
	// Length of the current clock hold
	// ---------------------------------------------------------------
	int hold_cnt;
	always_ff @(posedge core_clk) begin
		if (!reset_n || !twi_scl_oe) begin
			hold_cnt <= 0;
		end else begin
			hold_cnt <= hold_cnt + 1;
		end
	end

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	a_twi_off_sync: assert property (
		port_mode == hsps_pkg::HSPS_SYNC4 |-> !twi_scl_oe && !twi_sda_oe)
		else $error("two-wire pin driven in four-wire mode");
	a_miso_needs_select: assert property (
		spi_miso_oe |-> !spi_cs_n && port_mode == hsps_pkg::HSPS_SYNC4)
		else $error("four-wire output driven without select");
	a_uart_quiet_sync: assert property (
		port_mode == hsps_pkg::HSPS_SYNC4 |-> uart_txd)
		else $error("serial output active in four-wire mode");
	a_src_sync_only: assert property (
		rx_valid && port_mode == hsps_pkg::HSPS_SYNC4 |-> rx_byte.src == hsps_pkg::SRC_SPI)
		else $error("non four-wire byte in four-wire mode");
	a_src_async_only: assert property (
		rx_valid && port_mode == hsps_pkg::HSPS_ASYNC_TWI |-> rx_byte.src != hsps_pkg::SRC_SPI)
		else $error("four-wire byte in serial mode");
	a_mode_latched: assert property (
		$changed(port_mode) |-> !$past(reset_n) || !$past(reset_n, 2))
		else $error("port mode changed outside reset");
	a_start_bit_low: assert property (
		$fell(uart_txd) |-> !uart_txd [*8])
		else $error("start bit too short");
	a_reset_idle: assert property (
		$rose(reset_n) |-> uart_txd && !twi_scl_oe && !twi_sda_oe && !rx_valid)
		else $error("outputs not idle after reset");
	a_stretch_bound: assert property (
		hold_cnt <= STRETCH_LIMIT + 8)
		else $error("clock held low too long");
	a_data_before_release: assert property (
		$fell(twi_scl_oe) |-> $past(twi_sda_oe) == $past(twi_sda_oe, 2))
		else $error("data changed just before clock release");
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the host port front end in both strap settings.
// Assumes the host model stands on every pin of the far side.
`timescale 1ns/100ps
module tb_top;
	localparam int LIMIT = 200;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic if_sel = 1'b1;
	logic [hsps_pkg::ACC_W-1:0] baud_inc = '0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic tx_ready, rx_valid, uart_rxd, uart_txd, spi_sck, spi_cs_n, spi_mosi;
	logic spi_miso_o, spi_miso_oe, twi_scl_i, twi_scl_o, twi_scl_oe;
	logic twi_sda_i, twi_sda_o, twi_sda_oe, got_flag;
	logic [7:0] got_byte, r, m, s;
	logic [8:0] ack9, dat9;
	hsps_pkg::hsps_rx_s rx_byte;
	hsps_pkg::hsps_mode_e port_mode;
	hsps_pkg::hsps_port_cfg_s port_cfg;
	hsps_pkg::hsps_rx_s exp_q[$];
	logic [7:0] host_q[$];
	logic [31:0] seed = 32'h259e;
	int bad_count = 0;
	int comparisons = 0;
	int n;
	realtime t0;

	initial begin
		forever begin
			#25 core_clk = ~core_clk;
		end
	end

	hsps_top #(.STRETCH_LIMIT(LIMIT)) DUT (.core_clk(core_clk), .reset_n(reset_n),
		.if_sel(if_sel), .baud_inc(baud_inc), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .port_mode(port_mode),
		.port_cfg(port_cfg), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
		.spi_miso_oe(spi_miso_oe), .twi_scl_i(twi_scl_i), .twi_scl_o(twi_scl_o),
		.twi_scl_oe(twi_scl_oe), .twi_sda_i(twi_sda_i), .twi_sda_o(twi_sda_o),
		.twi_sda_oe(twi_sda_oe));
	hsps_host_model host (.uart_rxd(uart_rxd), .uart_txd(uart_txd), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
		.spi_miso_oe(spi_miso_oe), .twi_scl_i(twi_scl_i), .twi_sda_i(twi_sda_i),
		.twi_scl_o(twi_scl_o), .twi_scl_oe(twi_scl_oe), .twi_sda_o(twi_sda_o),
		.twi_sda_oe(twi_sda_oe), .got_byte(got_byte), .got_flag(got_flag));

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic do_reset(input logic sel);
		reset_n <= 1'b0;
		if_sel <= sel;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic push(input logic [7:0] b);
		tx_data <= b;
		tx_valid <= 1'b1;
		host_q.push_back(b);
		@(posedge core_clk);
		while (tx_ready !== 1'b1) @(posedge core_clk);
		tx_valid <= 1'b0;
		@(posedge core_clk);
	endtask

	// ---------------------------------------------------------------
	// Result watchers: oldest note against each arriving byte
	// ---------------------------------------------------------------
	always @(posedge core_clk) begin
		if (rx_valid === 1'b1) begin
			check({6'h00, rx_byte}, exp_q.size() > 0 ? {6'h00, exp_q.pop_front()} : 16'hdead);
		end
	end
	always @(posedge got_flag) begin
		check({8'h00, got_byte}, host_q.size() > 0 ? {8'h00, host_q.pop_front()} : 16'hdead);
	end

	initial begin
		#3_000_000;
		bad_count++;
		report_and_stop();
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		do_reset(1'b1);
		check({15'h0000, port_mode}, 16'h0000);
		check(port_cfg, 16'hfffc);
		check({14'h0000, uart_txd, spi_miso_oe}, 16'h0002);
		// Out-of-range increment falls back to the default rate
		r = rnd() | 8'h01;
		fork
			begin
				@(negedge uart_txd) t0 = $realtime;
				@(posedge uart_txd) check(($realtime - t0) > 8593 && ($realtime - t0) < 8768, 1);
			end
			push(r);
		join
		wait (host_q.size() == 0);
		$display("default framing test done");
		for (int i = 0; i < 3; i++) begin
			baud_inc <= i == 2 ? hsps_pkg::BAUD_INC_MIN : hsps_pkg::BAUD_INC_MAX;
			host.rx_bit_ns = i == 2 ? 1e9 / 9600.0 : 1e9 / 921600.0;
			r = rnd();
			exp_q.push_back({hsps_pkg::SRC_UART, r});
			@(posedge core_clk);
			fork
				host.uart_send(r, host.rx_bit_ns / (i == 0 ? 1.025 : i == 1 ? 0.975 : 1.0));
				push(rnd());
			join
			wait (host_q.size() == 0 && exp_q.size() == 0);
		end
		$display("rate range test done");
		// Fill until refused while the serial side drains
		baud_inc <= hsps_pkg::BAUD_INC_MAX;
		host.rx_bit_ns = 1e9 / 921600.0;
		// Let the last frame end so the fill count is exact
		repeat (30) @(posedge core_clk);
		n = 0;
		tx_valid <= 1'b1;
		tx_data <= rnd();
		@(posedge core_clk);
		while (tx_ready === 1'b1 && n < 9) begin
			host_q.push_back(tx_data);
			n++;
			tx_data <= rnd();
			@(posedge core_clk);
		end
		tx_valid <= 1'b0;
		check(16'(n), 16'h0005);
		wait (host_q.size() == 0);
		$display("buffer fill test done");
		m = rnd();
		exp_q.push_back({hsps_pkg::SRC_TWI, m});
		host.twi_xfer(hsps_pkg::TWI_ADDR_DEFAULT, 1'b0, m, ack9, dat9);
		check({14'h0000, ack9[0], dat9[0]}, 16'h0000);
		host.twi_xfer(hsps_pkg::TWI_ADDR_DEFAULT ^ 7'h01, 1'b0, m, ack9, dat9);
		check({15'h0000, ack9[0]}, 16'h0001);
		host.twi_xfer(hsps_pkg::TWI_ADDR_DEFAULT, 1'b1, m, ack9, dat9);
		check({7'h00, ack9[0], dat9[8:1]}, 16'h00ff);
		$display("two-wire test done");
		@(posedge core_clk);
		do_reset(1'b0);
		check({15'h0000, port_mode}, 16'h0001);
		check(port_cfg, 16'hfffc);
		r = rnd();
		push(r);
		void'(host_q.pop_back());
		repeat (6) @(posedge core_clk);
		for (int k = 0; k < 3; k++) begin
			m = rnd();
			exp_q.push_back({hsps_pkg::SRC_SPI, m});
			host.spi_xfer(m, s);
			repeat (160) @(posedge core_clk);
			if (k > 0) check({8'h00, s}, {8'h00, k == 1 ? r : 8'hff});
		end
		host.uart_send(rnd(), 1e9 / 921600.0);
		host.twi_xfer(hsps_pkg::TWI_ADDR_DEFAULT, 1'b0, m, ack9, dat9);
		check({15'h0000, ack9[0]}, 16'h0001);
		repeat (20) @(posedge core_clk);
		$display("four-wire test done");
		report_and_stop();
	end
endmodule

bind hsps_top hsps_checker #(.STRETCH_LIMIT(STRETCH_LIMIT)) u_props (.core_clk(core_clk),
	.reset_n(reset_n), .spi_cs_n(spi_cs_n), .uart_txd(uart_txd), .rx_valid(rx_valid),
	.rx_byte(rx_byte), .port_mode(port_mode), .spi_miso_oe(spi_miso_oe),
	.twi_scl_oe(twi_scl_oe), .twi_sda_oe(twi_sda_oe));

// ===== verilog/hsps_pkg.sv
// Constants, types and reset defaults for the host serial port select block.
// Assumes a 20 MHz core clock; every cycle count below is derived from that rate.
package hsps_pkg;
	// ---------------------------------------------------------------
	// Clock and asynchronous port timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int BAUD_MIN = 9600;
	localparam int BAUD_MAX = 921600;
	localparam int BAUD_DEFAULT = 115200;
	localparam int OVERSAMPLE = 16;
	localparam int ACC_W = 20;
	localparam longint ACC_SPAN = 64'd1 << ACC_W;
	localparam logic [ACC_W-1:0] BAUD_INC_DEFAULT =
		ACC_W'(longint'(BAUD_DEFAULT) * OVERSAMPLE * ACC_SPAN / CLK_HZ);
	localparam logic [ACC_W-1:0] BAUD_INC_MIN =
		ACC_W'(longint'(BAUD_MIN) * OVERSAMPLE * ACC_SPAN / CLK_HZ);
	localparam logic [ACC_W-1:0] BAUD_INC_MAX =
		ACC_W'(longint'(BAUD_MAX) * OVERSAMPLE * ACC_SPAN / CLK_HZ);
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] FRAME_LAST = 4'h9;
	localparam logic [3:0] RX_STOP_IDX = 4'h9;
	localparam logic [3:0] RX_START_IDX = 4'h0;
	localparam logic START_LEVEL = 1'b0;
	localparam logic STOP_LEVEL = 1'b1;
	localparam logic [9:0] TX_IDLE_FRAME = 10'h3ff;

	// ---------------------------------------------------------------
	// Synchronous four-wire and two-wire ports
	// ---------------------------------------------------------------
	localparam logic [7:0] SPI_FILL = 8'hff;
	localparam logic [2:0] SPI_LAST_BIT = 3'h7;
	localparam logic [6:0] TWI_ADDR_DEFAULT = 7'h2a;
	localparam int STRETCH_MAX_MS = 20;
	localparam int STRETCH_CYCLES = STRETCH_MAX_MS * (CLK_HZ / 1000);
	localparam int SU_DAT_NS = 100;
	localparam int SU_DAT_CYC = (SU_DAT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] TWI_FILL = 8'hff;

	typedef enum logic {
		HSPS_ASYNC_TWI = 1'b0,
		HSPS_SYNC4 = 1'b1
	} hsps_mode_e;

	typedef enum logic [3:0] {
		TWI_IDLE = 4'h0,
		TWI_ADDR = 4'h1,
		TWI_AACK = 4'h2,
		TWI_WR = 4'h3,
		TWI_WACK = 4'h4,
		TWI_LOAD = 4'h5,
		TWI_SETUP = 4'h6,
		TWI_RD = 4'h7,
		TWI_RACK = 4'h8
	} hsps_twi_e;

	typedef enum logic [1:0] {
		SRC_UART = 2'h0,
		SRC_TWI = 2'h1,
		SRC_SPI = 2'h2
	} hsps_src_e;

	typedef struct packed {
		hsps_src_e src;
		logic [7:0] data;
	} hsps_rx_s;

	typedef struct packed {
		logic gga;
		logic gll;
		logic gsa;
		logic gsv;
		logic rmc;
		logic vtg;
		logic txt;
		logic zda;
	} hsps_nmea_s;

	typedef struct packed {
		logic vendor_binary_protocol;
		logic nmea;
		logic rtcm3;
	} hsps_proto_s;

	typedef struct packed {
		hsps_nmea_s nmea_msgs;
		hsps_proto_s proto_out;
		hsps_proto_s proto_in;
		logic vendor_msgs;
		logic rtcm_msgs;
	} hsps_port_cfg_s;

	localparam hsps_port_cfg_s CFG_DEFAULT = '{
		nmea_msgs: 8'hff, proto_out: 3'h7, proto_in: 3'h7,
		vendor_msgs: 1'b0, rtcm_msgs: 1'b0};
endpackage

// ===== verilog/hsps_top.sv
// Host port front end: async serial, two-wire target and four-wire peripheral.
// Assumes pins arrive unsynchronised; spi_sck runs only while spi_cs_n is low.
`timescale 1ns/100ps

// ---------------------------------------------------------------
// Transmit FIFO
// ---------------------------------------------------------------
module hsps_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp;
	logic [AW:0] rp;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two, at least 2");
	end

	assign in_ready = (wp ^ rp) != {1'b1, {AW{1'b0}}};
	assign out_valid = wp != rp;
	assign out_data = mem[rp[AW-1:0]];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (push) wp <= wp + 1'b1;
			if (pop) rp <= rp + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) mem[wp[AW-1:0]] <= in_data;
	end
endmodule

// Every port shares one configuration; no flow-control pins exist.   
// What this block does
// - Async port enabled when the select strap is open or high.
// - Async port has no request-to-send or clear-to-send handshake.
// - Baud rate configurable from 9600 to 921600 bit/s.
// - Transmit rate within one percent; receiver tolerates 2.5 percent error.
// - Four-wire port off unless strap low; then it owns shared pins.
// - Two-wire port usable only when strap selects the async setting.
// - Four-wire port is peripheral only; host drives select and clock.
// - Four-wire port idles clock low, samples on rising edge.
// - Two-wire port uses Fast-mode timing only.
// - Two-wire port is an addressed target, clocked at most 400 kbit/s.
// - Device may hold two-wire clock low, at most 20 ms.
// - Data line valid a setup time before releasing a stretched clock.
// - Default async framing 115200 baud, 8 data bits, no parity, 1 stop.
// - Default NMEA output set GGA GLL GSA GSV RMC VTG TXT ZDA.
// - Binary and RTCM output enabled by default, no messages scheduled.
// - Receiver accepts binary, NMEA and RTCM input by default.
// - All host ports share the async port's defaults.
module hsps_top #(
	parameter int FIFO_DEPTH = 4,
	parameter int STRETCH_LIMIT = hsps_pkg::STRETCH_CYCLES,
	parameter logic [6:0] TWI_ADDR = hsps_pkg::TWI_ADDR_DEFAULT
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic if_sel,
	input wire logic [hsps_pkg::ACC_W-1:0] baud_inc,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output hsps_pkg::hsps_rx_s rx_byte,
	output logic rx_valid,
	output hsps_pkg::hsps_mode_e port_mode,
	output hsps_pkg::hsps_port_cfg_s port_cfg,
	input wire logic uart_rxd,
	output logic uart_txd,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso_o,
	output logic spi_miso_oe,
	input wire logic twi_scl_i,
	output logic twi_scl_o,
	output logic twi_scl_oe,
	input wire logic twi_sda_i,
	output logic twi_sda_o,
	output logic twi_sda_oe
);
	if (FIFO_DEPTH < 2 || STRETCH_LIMIT < 1 || STRETCH_LIMIT > 2**24 - 1) begin : g_bad
		$error("Unsupported FIFO depth or stretch limit");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers and strap capture
	// ---------------------------------------------------------------
	logic [1:0] sel_s;
	logic [1:0] rxd_s;
	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic scl_p;
	logic sda_p;
	logic strap_done;
	always_ff @(posedge core_clk) begin
		sel_s <= {sel_s[0], if_sel};
		rxd_s <= {rxd_s[0], uart_rxd};
		scl_s <= {scl_s[0], twi_scl_i};
		sda_s <= {sda_s[0], twi_sda_i};
		scl_p <= scl_s[1];
		sda_p <= sda_s[1];
	end

	// Strap is caught once after reset release so pins cannot swap mid-run
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			strap_done <= 1'b0;
			port_mode <= hsps_pkg::HSPS_ASYNC_TWI;
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			port_mode <= sel_s[1] ? hsps_pkg::HSPS_ASYNC_TWI : hsps_pkg::HSPS_SYNC4;
		end
	end
	wire sync4 = port_mode == hsps_pkg::HSPS_SYNC4;

	// One configuration set serves every host port
	always_ff @(posedge core_clk) begin
		port_cfg <= hsps_pkg::CFG_DEFAULT;
	end

	// ---------------------------------------------------------------
	// Transmit FIFO and consumers
	// ---------------------------------------------------------------
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic uart_take;
	logic twi_take;
	logic spi_take;
	hsps_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(core_clk),
		.reset_n(reset_n),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(uart_take | twi_take | spi_take)
	);

	// ---------------------------------------------------------------
	// Baud generator at sixteen times the bit rate
	// ---------------------------------------------------------------
	// Phase accumulator keeps rate error far inside the tolerance
	logic [hsps_pkg::ACC_W:0] acc;
	wire inc_ok = baud_inc >= hsps_pkg::BAUD_INC_MIN && baud_inc <= hsps_pkg::BAUD_INC_MAX;
	wire [hsps_pkg::ACC_W-1:0] inc_eff = inc_ok ? baud_inc : hsps_pkg::BAUD_INC_DEFAULT;
	wire tick = acc[hsps_pkg::ACC_W];
	always_ff @(posedge core_clk) begin
		if (!reset_n) acc <= '0;
		else acc <= {1'b0, acc[hsps_pkg::ACC_W-1:0]} + {1'b0, inc_eff};
	end

	// ---------------------------------------------------------------
	// Async transmitter, no flow-control lines
	// ---------------------------------------------------------------
	logic tx_act;
	logic [3:0] tx_os;
	logic [3:0] tx_n;
	logic [9:0] tx_sh;
	// Frames start on a tick so the start bit gets its full sixteen ticks
	assign uart_take = !sync4 && !tx_act && fifo_valid && !twi_take && tick;
	assign uart_txd = tx_sh[0];
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tx_act <= 1'b0;
			tx_os <= '0;
			tx_n <= '0;
			tx_sh <= hsps_pkg::TX_IDLE_FRAME;
		end else if (uart_take) begin
			tx_act <= 1'b1;
			tx_os <= '0;
			tx_n <= '0;
			tx_sh <= {hsps_pkg::STOP_LEVEL, fifo_data, hsps_pkg::START_LEVEL};
		end else if (tx_act && tick) begin
			tx_os <= tx_os + 1'b1;
			if (tx_os == hsps_pkg::OS_LAST) begin
				tx_sh <= {hsps_pkg::STOP_LEVEL, tx_sh[9:1]};
				tx_n <= tx_n + 1'b1;
				if (tx_n == hsps_pkg::FRAME_LAST) tx_act <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Async receiver, mid-bit sampling
	// ---------------------------------------------------------------
	logic rx_act;
	logic [3:0] rx_os;
	logic [3:0] rx_n;
	logic [7:0] rx_sh;
	logic uart_got;
	wire rxd = rxd_s[1] | sync4;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rx_act <= 1'b0;
			rx_os <= '0;
			rx_n <= '0;
			rx_sh <= '0;
			uart_got <= 1'b0;
		end else begin
			uart_got <= 1'b0;
			if (tick && !rx_act && rxd == hsps_pkg::START_LEVEL) begin
				rx_act <= 1'b1;
				rx_os <= '0;
				rx_n <= hsps_pkg::RX_START_IDX;
			end else if (tick && rx_act) begin
				rx_os <= rx_os + 1'b1;
				if (rx_os == hsps_pkg::OS_MID) begin
					rx_n <= rx_n + 1'b1;
					if (rx_n == hsps_pkg::RX_START_IDX && rxd != hsps_pkg::START_LEVEL) begin
						rx_act <= 1'b0;
					end else if (rx_n == hsps_pkg::RX_STOP_IDX) begin
						rx_act <= 1'b0;
						uart_got <= rxd == hsps_pkg::STOP_LEVEL;
					end else if (rx_n != hsps_pkg::RX_START_IDX) begin
						rx_sh <= {rxd, rx_sh[7:1]};
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Four-wire peripheral, link clock domain
	// ---------------------------------------------------------------
	// Counters restart on chip select high because the clock stops between frames
	logic [2:0] bitc;
	logic [6:0] rsh;
	logic [7:0] rbyte;
	logic rtog;
	logic [7:0] tsh;
	logic first_done;
	logic ttog;
	logic [7:0] spi_hold;
	always_ff @(posedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			bitc <= '0;
			rsh <= '0;
		end else begin
			bitc <= bitc + 1'b1;
			rsh <= {rsh[5:0], spi_mosi};
		end
	end
	always_ff @(posedge spi_sck or negedge reset_n) begin
		if (!reset_n) begin
			rtog <= 1'b0;
			rbyte <= '0;
		end else if (bitc == hsps_pkg::SPI_LAST_BIT) begin
			rtog <= ~rtog;
			rbyte <= {rsh, spi_mosi};
		end
	end
	// Outgoing bits change on falling edges only, mode zero
	always_ff @(negedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			first_done <= 1'b0;
			tsh <= '0;
		end else begin
			first_done <= 1'b1;
			if (bitc == 3'h0) tsh <= spi_hold;
			else tsh <= first_done ? {tsh[6:0], 1'b0} : {spi_hold[6:0], 1'b0};
		end
	end
	// Refill only once a byte is really shifting; a frame end must not waste the hold
	always_ff @(negedge spi_sck or negedge reset_n) begin
		if (!reset_n) ttog <= 1'b0;
		else if (!spi_cs_n && bitc == 3'h1) ttog <= ~ttog;
	end
	assign spi_miso_o = first_done ? tsh[7] : spi_hold[7];
	assign spi_miso_oe = sync4 && !spi_cs_n;

	// Toggle crossings; spi_hold is only rewritten after the link took it
	logic [2:0] rtog_s;
	logic [2:0] ttog_s;
	logic spi_got;
	logic [7:0] spi_rx;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rtog_s <= '0;
			ttog_s <= '0;
		end else begin
			rtog_s <= {rtog_s[1:0], rtog};
			ttog_s <= {ttog_s[1:0], ttog};
		end
	end
	wire spi_rx_evt = rtog_s[2] ^ rtog_s[1];
	wire spi_tx_evt = ttog_s[2] ^ ttog_s[1];
	assign spi_take = sync4 && spi_tx_evt && fifo_valid;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			spi_hold <= hsps_pkg::SPI_FILL;
			spi_got <= 1'b0;
			spi_rx <= '0;
		end else begin
			spi_got <= sync4 && spi_rx_evt;
			if (spi_rx_evt) spi_rx <= rbyte;
			if (spi_tx_evt) spi_hold <= fifo_valid ? fifo_data : hsps_pkg::SPI_FILL;
		end
	end

	// ---------------------------------------------------------------
	// Two-wire target, Fast-mode
	// ---------------------------------------------------------------
	hsps_pkg::hsps_twi_e tst;
	logic [2:0] tcnt;
	logic [7:0] tsr;
	logic trw;
	logic tack_on;
	logic sda_low;
	logic scl_low;
	logic [23:0] stretch;
	logic twi_got;
	wire scl_rise = scl_s[1] && !scl_p;
	wire scl_fall = !scl_s[1] && scl_p;
	wire t_start = scl_s[1] && scl_p && sda_p && !sda_s[1];
	wire t_stop = scl_s[1] && scl_p && !sda_p && sda_s[1];
	wire stretch_end = stretch == 24'(STRETCH_LIMIT - 1);
	assign twi_take = tst == hsps_pkg::TWI_LOAD && fifo_valid;
	assign twi_scl_o = 1'b0;
	assign twi_sda_o = 1'b0;
	assign twi_scl_oe = scl_low;
	assign twi_sda_oe = sda_low;
	always_ff @(posedge core_clk) begin
		if (!reset_n || sync4) begin
			tst <= hsps_pkg::TWI_IDLE;
			tcnt <= '0;
			tsr <= '0;
			trw <= 1'b0;
			tack_on <= 1'b0;
			sda_low <= 1'b0;
			scl_low <= 1'b0;
			stretch <= '0;
			twi_got <= 1'b0;
		end else begin
			twi_got <= 1'b0;
			if (t_start) begin
				tst <= hsps_pkg::TWI_ADDR;
				tcnt <= '0;
				sda_low <= 1'b0;
				scl_low <= 1'b0;
			end else if (t_stop) begin
				tst <= hsps_pkg::TWI_IDLE;
				sda_low <= 1'b0;
				scl_low <= 1'b0;
			end else begin
				case (tst)
					hsps_pkg::TWI_ADDR, hsps_pkg::TWI_WR: begin
						if (scl_rise) begin
							tsr <= {tsr[6:0], sda_s[1]};
							tcnt <= tcnt + 1'b1;
							if (tcnt == 3'h7) begin
								tack_on <= 1'b0;
								if (tst == hsps_pkg::TWI_WR) begin
									twi_got <= 1'b1;
									tst <= hsps_pkg::TWI_WACK;
								end else if (tsr[6:0] == TWI_ADDR) begin
									trw <= sda_s[1];
									tst <= hsps_pkg::TWI_AACK;
								end else begin
									tst <= hsps_pkg::TWI_IDLE;
								end
							end
						end
					end
					hsps_pkg::TWI_AACK, hsps_pkg::TWI_WACK: begin
						if (scl_fall) begin
							tack_on <= 1'b1;
							sda_low <= !tack_on;
							if (tack_on) begin
								tcnt <= '0;
								stretch <= '0;
								if (tst == hsps_pkg::TWI_AACK && trw) tst <= hsps_pkg::TWI_LOAD;
								else tst <= hsps_pkg::TWI_WR;
							end
						end
					end
					hsps_pkg::TWI_LOAD: begin
						scl_low <= 1'b1;
						stretch <= stretch + 1'b1;
						if (fifo_valid || stretch_end) begin
							tsr <= fifo_valid ? fifo_data : hsps_pkg::TWI_FILL;
							sda_low <= fifo_valid ? !fifo_data[7] : !hsps_pkg::TWI_FILL[7];
							stretch <= '0;
							tst <= hsps_pkg::TWI_SETUP;
						end
					end
					hsps_pkg::TWI_SETUP: begin
						stretch <= stretch + 1'b1;
						if (stretch == 24'(hsps_pkg::SU_DAT_CYC - 1)) begin
							scl_low <= 1'b0;
							tcnt <= '0;
							tst <= hsps_pkg::TWI_RD;
						end
					end
					hsps_pkg::TWI_RD: begin
						if (scl_fall) begin
							tcnt <= tcnt + 1'b1;
							tsr <= {tsr[6:0], 1'b0};
							sda_low <= tcnt == 3'h7 ? 1'b0 : !tsr[6];
							if (tcnt == 3'h7) tst <= hsps_pkg::TWI_RACK;
						end
					end
					hsps_pkg::TWI_RACK: begin
						if (scl_rise) trw <= !sda_s[1];
						if (scl_fall) begin
							stretch <= '0;
							tst <= trw ? hsps_pkg::TWI_LOAD : hsps_pkg::TWI_IDLE;
						end
					end
					default: tst <= hsps_pkg::TWI_IDLE;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Received byte merge
	// ---------------------------------------------------------------
	// Collisions are rare; the four-wire port wins, then async, then two-wire
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rx_valid <= 1'b0;
			rx_byte <= '0;
		end else begin
			rx_valid <= uart_got | spi_got | twi_got;
			if (spi_got) rx_byte <= '{src: hsps_pkg::SRC_SPI, data: spi_rx};
			else if (uart_got) rx_byte <= '{src: hsps_pkg::SRC_UART, data: rx_sh};
			else if (twi_got) rx_byte <= '{src: hsps_pkg::SRC_TWI, data: tsr};
		end
	end
endmodule
